// ### include/prsc_pkg.sv
// Types shared by the reference state controller.
package prsc_pkg;

    typedef enum logic [1:0] {
        PRSC_FREE_RUN,
        PRSC_LOCK,
        PRSC_HOLDOVER
    } prsc_pll_state_type;

    typedef enum logic [1:0] {
        PRSC_CHOICE_AUTO,
        PRSC_CHOICE_REF0,
        PRSC_CHOICE_REF1,
        PRSC_CHOICE_PIN
    } prsc_choice_type;

    typedef enum logic [1:0] {
        PRSC_LD_IDLE,
        PRSC_LD_FETCH,
        PRSC_LD_WAIT
    } prsc_load_state_type;

endpackage

// ### include/prsc_regs.svh
// Register offsets, field positions, reset values and timing counts of the reference state controller.
`ifndef PRSC_REGS_SVH
`define PRSC_REGS_SVH

`define PRSC_ADDR_W 8
`define PRSC_OFF_CTRL 8'h00
`define PRSC_OFF_MON0 8'h04
`define PRSC_OFF_MON1 8'h08
`define PRSC_OFF_STATUS 8'h0C
`define PRSC_OFF_IRQ_STAT 8'h10
`define PRSC_OFF_IRQ_MASK 8'h14
`define PRSC_OFF_LOAD 8'h18

`define PRSC_CTRL_W 7
`define PRSC_CTRL_RESET 7'h00
`define PRSC_CTRL_CHOICE_LSB 0
`define PRSC_CTRL_REVERT_BIT 2
`define PRSC_CTRL_PRIO_BIT 3
`define PRSC_CTRL_HOLD_LSB 4
`define PRSC_CTRL_SRC_BIT 6

`define PRSC_MON_RESET 17'h00100

`define PRSC_IRQ_W 5
`define PRSC_IRQ_RESET 5'h00
`define PRSC_IRQ_LOS0_BIT 0
`define PRSC_IRQ_LOS1_BIT 1
`define PRSC_IRQ_LOCK_BIT 2
`define PRSC_IRQ_HOLD_BIT 3
`define PRSC_IRQ_LOAD_BIT 4

`define PRSC_LOAD_START_BIT 0
`define PRSC_LOAD_SRC_BIT 1

`define PRSC_VALIDATE_EDGES 4'h8
`define PRSC_LOAD_WORDS 2'h3

`endif

// ### rtl/prsc_top.sv
// Reference state controller: input monitors, reference selection, PLL state and register file.
`timescale 1ns/1ps
`default_nettype none
`include "prsc_regs.svh"

module prsc_top
    import prsc_pkg::*;
#(
    parameter int MON_W = 17,
    parameter logic [31:0] OTP_WORD0 = 32'h0000_0000,
    parameter logic [31:0] OTP_WORD1 = 32'h0000_0100,
    parameter logic [31:0] OTP_WORD2 = 32'h0000_0100,
    parameter logic [31:0] OTP_WORD3 = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PRSC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clk0,
    input wire logic ref_clk1,
    input wire logic clock_select_pin,
    output logic [1:0] pll_state,
    output logic selected_ref,
    output logic freeze_tracking,
    output logic hitless_switch,
    output logic [1:0] holdover_steer,
    output logic lock_status_pin,
    output logic holdover_status_pin,
    output logic [1:0] loss_of_signal_flag,
    output logic interrupt_out_n,
    output logic eeprom_rd_req,
    output logic [1:0] eeprom_rd_addr,
    input wire logic [31:0] eeprom_rd_data,
    input wire logic eeprom_rd_valid
);

    if (MON_W < 2 || MON_W > 17) begin : g_bad_width
        $error("MON_W must lie between 2 and 17");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and APB decode.

    logic [`PRSC_CTRL_W-1:0] ctrl_r;
    logic [MON_W-1:0] mon_target_r [2];
    logic [`PRSC_IRQ_W-1:0] irq_stat_r;
    logic [`PRSC_IRQ_W-1:0] irq_mask_r;
    logic [`PRSC_IRQ_W-1:0] irq_event;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic apb_done;
    logic apb_wr;
    logic addr_ok;
    logic [31:0] rd_word;

    prsc_pll_state_type state_r;
    logic sel_r;
    logic [1:0] los_r;
    logic [1:0] soft_r;
    logic switch_r;
    logic irq_n_r;

    prsc_load_state_type ld_state_r;
    logic ld_src_r;
    logic [1:0] ld_idx_r;
    logic ld_pending_r;
    logic ld_word_ok;
    logic [31:0] ld_word;
    logic ld_done;
    logic eeprom_req_r;
    logic ld_cmd;

    // A one-cycle wait state lets read data leave from a flop.
    assign apb_done = psel && penable && pready_r;
    assign apb_wr = apb_done && pwrite && addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            `PRSC_OFF_CTRL: rd_word = 32'(ctrl_r);
            `PRSC_OFF_MON0: rd_word = 32'(mon_target_r[0]);
            `PRSC_OFF_MON1: rd_word = 32'(mon_target_r[1]);
            `PRSC_OFF_STATUS: rd_word = {24'h000000, ld_state_r != PRSC_LD_IDLE, soft_r, los_r, sel_r, state_r};
            `PRSC_OFF_IRQ_STAT: rd_word = 32'(irq_stat_r);
            `PRSC_OFF_IRQ_MASK: rd_word = 32'(irq_mask_r);
            `PRSC_OFF_LOAD: rd_word = {30'h00000000, ld_src_r, ld_state_r != PRSC_LD_IDLE};
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr_r <= !addr_ok;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // The loader wins over a software write that lands in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `PRSC_CTRL_RESET;
            mon_target_r[0] <= MON_W'(`PRSC_MON_RESET);
            mon_target_r[1] <= MON_W'(`PRSC_MON_RESET);
            irq_mask_r <= `PRSC_IRQ_RESET;
        end else if (ld_word_ok) begin
            case (ld_idx_r)
                2'h0: ctrl_r <= ld_word[`PRSC_CTRL_W-1:0];
                2'h1: mon_target_r[0] <= ld_word[MON_W-1:0];
                2'h2: mon_target_r[1] <= ld_word[MON_W-1:0];
                default: irq_mask_r <= ld_word[`PRSC_IRQ_W-1:0];
            endcase
        end else if (apb_wr) begin
            case (paddr)
                `PRSC_OFF_CTRL: ctrl_r <= pwdata[`PRSC_CTRL_W-1:0];
                `PRSC_OFF_MON0: mon_target_r[0] <= pwdata[MON_W-1:0];
                `PRSC_OFF_MON1: mon_target_r[1] <= pwdata[MON_W-1:0];
                `PRSC_OFF_IRQ_MASK: irq_mask_r <= pwdata[`PRSC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three flops; a select pin change counts once the last two agree, a reference rising edge when the middle one is high and the last low.

    logic [2:0] ref0_sync_r;
    logic [2:0] ref1_sync_r;
    logic [2:0] clock_select_pin_sync_r;
    logic clock_select_pin_r;
    logic [1:0] ref_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref0_sync_r <= 3'h0;
            ref1_sync_r <= 3'h0;
            clock_select_pin_sync_r <= 3'h0;
            clock_select_pin_r <= 1'b0;
        end else begin
            ref0_sync_r <= {ref0_sync_r[1:0], ref_clk0};
            ref1_sync_r <= {ref1_sync_r[1:0], ref_clk1};
            clock_select_pin_sync_r <= {clock_select_pin_sync_r[1:0], clock_select_pin};
            if (clock_select_pin_sync_r[1] == clock_select_pin_sync_r[2]) begin
                clock_select_pin_r <= clock_select_pin_sync_r[2];
            end
        end
    end

    assign ref_edge[0] = ref0_sync_r[1] && !ref0_sync_r[2];
    assign ref_edge[1] = ref1_sync_r[1] && !ref1_sync_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Input monitors.

    logic [MON_W-1:0] mon_cnt_r [2];
    logic [3:0] val_cnt_r [2];
    logic [1:0] los_set;
    logic [1:0] los_clr;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            los_set[i] = !ref_edge[i] && mon_cnt_r[i] >= mon_target_r[i] && soft_r[i] && !los_r[i];
            los_clr[i] = ref_edge[i] && los_r[i] && val_cnt_r[i] == `PRSC_VALIDATE_EDGES - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                mon_cnt_r[i] <= '0;
                val_cnt_r[i] <= 4'h0;
            end
            soft_r <= 2'b00;
            // Both inputs count as failed until they have been validated.
            los_r <= 2'b11;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ref_edge[i]) begin
                    mon_cnt_r[i] <= '0;
                    soft_r[i] <= 1'b0;
                    if (los_clr[i]) begin
                        los_r[i] <= 1'b0;
                        val_cnt_r[i] <= 4'h0;
                    end else if (los_r[i]) begin
                        val_cnt_r[i] <= val_cnt_r[i] + 4'h1;
                    end
                end else if (mon_cnt_r[i] >= mon_target_r[i]) begin
                    mon_cnt_r[i] <= '0;
                    if (soft_r[i]) begin
                        los_r[i] <= 1'b1;
                    end
                    soft_r[i] <= 1'b1;
                    val_cnt_r[i] <= 4'h0;
                end else begin
                    mon_cnt_r[i] <= mon_cnt_r[i] + MON_W'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference selection and PLL state.

    prsc_choice_type choice;
    logic revertive;
    logic prio_ref;
    logic [1:0] valid;
    logic sel_nxt;

    assign choice = prsc_choice_type'(ctrl_r[`PRSC_CTRL_CHOICE_LSB +: 2]);
    assign revertive = ctrl_r[`PRSC_CTRL_REVERT_BIT];
    assign prio_ref = ctrl_r[`PRSC_CTRL_PRIO_BIT];
    assign valid = ~los_r;

    always_comb begin
        sel_nxt = sel_r;
        case (choice)
            PRSC_CHOICE_AUTO: begin
                if (valid[prio_ref] && (revertive || !valid[sel_r])) begin
                    sel_nxt = prio_ref;
                end else if (!valid[sel_r] && valid[!sel_r]) begin
                    sel_nxt = !sel_r;
                end
            end
            PRSC_CHOICE_REF0: sel_nxt = 1'b0;
            PRSC_CHOICE_REF1: sel_nxt = 1'b1;
            PRSC_CHOICE_PIN: sel_nxt = clock_select_pin_r;
            default: sel_nxt = sel_r;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PRSC_FREE_RUN;
            sel_r <= 1'b0;
            switch_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            // A change to a valid input while locked keeps the loop closed and flags a hitless switch.
            switch_r <= state_r == PRSC_LOCK && sel_nxt != sel_r && valid[sel_nxt];
            case (state_r)
                PRSC_FREE_RUN: begin
                    if (valid[sel_nxt]) begin
                        state_r <= PRSC_LOCK;
                    end
                end
                PRSC_LOCK: begin
                    if (!valid[sel_nxt]) begin
                        state_r <= PRSC_HOLDOVER;
                    end
                end
                PRSC_HOLDOVER: begin
                    if (valid[sel_nxt]) begin
                        state_r <= PRSC_LOCK;
                    end
                end
                default: state_r <= PRSC_FREE_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a write-one clear in the same cycle.

    assign irq_event[`PRSC_IRQ_LOS0_BIT] = los_set[0] || los_clr[0];
    assign irq_event[`PRSC_IRQ_LOS1_BIT] = los_set[1] || los_clr[1];
    assign irq_event[`PRSC_IRQ_LOCK_BIT] = state_r != PRSC_LOCK && valid[sel_nxt];
    assign irq_event[`PRSC_IRQ_HOLD_BIT] = state_r == PRSC_LOCK && !valid[sel_nxt];
    assign irq_event[`PRSC_IRQ_LOAD_BIT] = ld_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= `PRSC_IRQ_RESET;
            irq_n_r <= 1'b1;
        end else begin
            if (apb_wr && paddr == `PRSC_OFF_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[`PRSC_IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat_r <= irq_stat_r | irq_event;
            end
            irq_n_r <= ~|(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings loader: after reset from OTP, later on command from either source.

    assign ld_cmd = apb_wr && paddr == `PRSC_OFF_LOAD && pwdata[`PRSC_LOAD_START_BIT];
    assign ld_word_ok = (ld_state_r == PRSC_LD_FETCH && !ld_src_r) ||
                        (ld_state_r == PRSC_LD_WAIT && eeprom_rd_valid);
    assign ld_done = ld_word_ok && ld_idx_r == `PRSC_LOAD_WORDS;

    always_comb begin
        case (ld_idx_r)
            2'h0: ld_word = ld_src_r ? eeprom_rd_data : OTP_WORD0;
            2'h1: ld_word = ld_src_r ? eeprom_rd_data : OTP_WORD1;
            2'h2: ld_word = ld_src_r ? eeprom_rd_data : OTP_WORD2;
            default: ld_word = ld_src_r ? eeprom_rd_data : OTP_WORD3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_state_r <= PRSC_LD_IDLE;
            ld_src_r <= 1'b0;
            ld_idx_r <= 2'h0;
            ld_pending_r <= 1'b1;
            eeprom_req_r <= 1'b0;
        end else begin
            case (ld_state_r)
                PRSC_LD_IDLE: begin
                    if (ld_pending_r || ld_cmd) begin
                        ld_pending_r <= 1'b0;
                        ld_src_r <= ld_cmd ? pwdata[`PRSC_LOAD_SRC_BIT] : ctrl_r[`PRSC_CTRL_SRC_BIT];
                        ld_idx_r <= 2'h0;
                        ld_state_r <= PRSC_LD_FETCH;
                    end
                end
                PRSC_LD_FETCH: begin
                    if (ld_src_r) begin
                        eeprom_req_r <= 1'b1;
                        ld_state_r <= PRSC_LD_WAIT;
                    end else if (ld_done) begin
                        ld_state_r <= PRSC_LD_IDLE;
                    end else begin
                        ld_idx_r <= ld_idx_r + 2'h1;
                    end
                end
                PRSC_LD_WAIT: begin
                    if (eeprom_rd_valid) begin
                        eeprom_req_r <= 1'b0;
                        ld_state_r <= ld_done ? PRSC_LD_IDLE : PRSC_LD_FETCH;
                        ld_idx_r <= ld_done ? ld_idx_r : ld_idx_r + 2'h1;
                    end
                end
                default: ld_state_r <= PRSC_LD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_tracking <= 1'b0;
            holdover_steer <= 2'b00;
            lock_status_pin <= 1'b0;
            holdover_status_pin <= 1'b0;
            loss_of_signal_flag <= 2'b11;
            eeprom_rd_addr <= 2'h0;
        end else begin
            freeze_tracking <= state_r == PRSC_LOCK && soft_r[sel_r];
            holdover_steer <= state_r == PRSC_HOLDOVER ? ctrl_r[`PRSC_CTRL_HOLD_LSB +: 2] : 2'b00;
            lock_status_pin <= state_r == PRSC_LOCK;
            holdover_status_pin <= state_r == PRSC_HOLDOVER;
            loss_of_signal_flag <= los_r;
            eeprom_rd_addr <= ld_idx_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pll_state = state_r;
    assign selected_ref = sel_r;
    assign hitless_switch = switch_r;
    assign interrupt_out_n = irq_n_r;
    assign eeprom_rd_req = eeprom_req_r;

endmodule

`default_nettype wire

// ### tb/prsc_far_model.sv
// Reference clock sources and serial memory front end facing the controller.
`timescale 1ns/1ps
`default_nettype none
module prsc_far_model (
    input wire logic pclk,
    input wire logic run0,
    input wire logic run1,
    input wire logic eeprom_rd_req,
    input wire logic [1:0] eeprom_rd_addr,
    output logic ref_clk0,
    output logic ref_clk1,
    output logic [31:0] eeprom_rd_data,
    output var logic eeprom_rd_valid
);
    logic [2:0] ph_r = 3'h0;
    logic [2:0] wait_r = 3'h0;
    logic [31:0] word;
////////////////////
    // A stopped source sits low, as the input pull-down would leave it.
    always_ff @(posedge pclk) begin
        ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
    end
    assign ref_clk0 = run0 && (ph_r < 3'h3);
    assign ref_clk1 = run1 && (ph_r >= 3'h3);
////////////////////
    always_comb begin
        case (eeprom_rd_addr)
            2'h0: word = 32'h0000_0020;
            2'h3: word = 32'h0000_0000;
            default: word = 32'h0000_0012;
        endcase
    end
    // Odd words answer slowly, even words promptly.
    always_ff @(posedge pclk) begin
        eeprom_rd_valid <= 1'b0;
        if (eeprom_rd_req && !eeprom_rd_valid) begin
            wait_r <= wait_r + 3'h1;
            if (wait_r == (eeprom_rd_addr[0] ? 3'h4 : 3'h1)) begin
                eeprom_rd_valid <= 1'b1;
                wait_r <= 3'h0;
            end
        end
    end
    assign eeprom_rd_data = eeprom_rd_valid ? word : ~word;
endmodule
`default_nettype wire

// ### tb/prsc_top_props.sv
// Port assertions for the reference state controller.
`timescale 1ns/1ps
`default_nettype none
module prsc_top_props
    import prsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [1:0] pll_state,
    input wire logic hitless_switch,
    input wire logic [1:0] holdover_steer,
    input wire logic lock_status_pin,
    input wire logic holdover_status_pin,
    input wire logic eeprom_rd_req,
    input wire logic eeprom_rd_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
////////////////////
    a_reset_free_run: assert property (!$past(presetn) |-> pll_state == PRSC_FREE_RUN)
        else $error("state not free-run after reset");
    a_three_states: assert property (pll_state != 2'h3)
        else $error("state encoding out of range");
    a_free_run_gone: assert property (pll_state != PRSC_FREE_RUN |=> pll_state != PRSC_FREE_RUN)
        else $error("returned to free-run without reset");
    a_leave_to_lock: assert property (pll_state == PRSC_FREE_RUN ##1 pll_state != PRSC_FREE_RUN
        |-> pll_state == PRSC_LOCK)
        else $error("free-run left to a state other than lock");
    // Pins may trail the state by one cycle, so they are judged once the state has settled.
    a_status_pins: assert property ($stable(pll_state) |-> lock_status_pin == (pll_state == PRSC_LOCK)
        && holdover_status_pin == (pll_state == PRSC_HOLDOVER))
        else $error("status pins disagree with state");
    a_steer_idle: assert property ($stable(pll_state) && pll_state != PRSC_HOLDOVER |-> holdover_steer == 2'h0)
        else $error("steering active outside holdover");
    a_hitless_lock: assert property (hitless_switch |-> pll_state == PRSC_LOCK ##1 !hitless_switch)
        else $error("switch pulse outside lock or too long");
    a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    a_eeprom_req_hold: assert property (eeprom_rd_req && !eeprom_rd_valid |=> eeprom_rd_req)
        else $error("memory request dropped before data");
    c_lock: cover property (pll_state == PRSC_LOCK);
    c_hold: cover property (pll_state == PRSC_HOLDOVER);
    c_hitless: cover property (hitless_switch);
endmodule
bind prsc_top prsc_top_props u_props (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pll_state(pll_state),
    .hitless_switch(hitless_switch),
    .holdover_steer(holdover_steer),
    .lock_status_pin(lock_status_pin),
    .holdover_status_pin(holdover_status_pin),
    .eeprom_rd_req(eeprom_rd_req),
    .eeprom_rd_valid(eeprom_rd_valid)
);
`default_nettype wire

// ### tb/prsc_top_tb_top.sv
// Self-checking bench for the reference state controller.
`timescale 1ns/1ps
`default_nettype none
module prsc_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic clock_select_pin = 1'b0;
    logic run0 = 1'b0;
    logic run1 = 1'b0;
    logic [31:0] prdata, eeprom_rd_data, rd;
    logic pready, pslverr, ref_clk0, ref_clk1, selected_ref, freeze_tracking, hitless_switch, err;
    logic lock_status_pin, holdover_status_pin, interrupt_out_n, eeprom_rd_req, eeprom_rd_valid;
    logic [1:0] pll_state, holdover_steer, loss_of_signal_flag, eeprom_rd_addr;
    int failures = 0;
    int compares = 0;
    always #12.5 pclk = ~pclk;
    prsc_top #(.OTP_WORD1(32'h0000_0010), .OTP_WORD2(32'h0000_0010)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1),
        .clock_select_pin(clock_select_pin), .pll_state(pll_state), .selected_ref(selected_ref),
        .freeze_tracking(freeze_tracking), .hitless_switch(hitless_switch), .holdover_steer(holdover_steer),
        .lock_status_pin(lock_status_pin), .holdover_status_pin(holdover_status_pin),
        .loss_of_signal_flag(loss_of_signal_flag), .interrupt_out_n(interrupt_out_n),
        .eeprom_rd_req(eeprom_rd_req), .eeprom_rd_addr(eeprom_rd_addr), .eeprom_rd_data(eeprom_rd_data),
        .eeprom_rd_valid(eeprom_rd_valid));
    prsc_far_model far (.pclk(pclk), .run0(run0), .run1(run1), .eeprom_rd_req(eeprom_rd_req),
        .eeprom_rd_addr(eeprom_rd_addr), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1),
        .eeprom_rd_data(eeprom_rd_data), .eeprom_rd_valid(eeprom_rd_valid));
////////////////////
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 500) begin
            failures++;
            $display("wrong value wait expected done seen timeout");
            final_report;
        end
    endtask
    // The request stays put until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        bound(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
////////////////////
    task automatic t_reset;
        check("state", 32'(pll_state), 32'h0);
        check("los", 32'(loss_of_signal_flag), 32'h3);
        repeat (10) @(posedge pclk);
        apb(1'b0, 8'h10, 32'h0);
        check("load done", rd & 32'h10, 32'h10);
        apb(1'b1, 8'h10, 32'h1F);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        repeat (100) @(posedge pclk);
        check("idle", 32'(pll_state), 32'h0);
    endtask
    task automatic t_lock;
        int n;
        run0 <= 1'b1;
        for (n = 0; n < 500 && pll_state !== 2'h1; n++) @(posedge pclk);
        bound(n);
        check("validation time", 32'(n >= 45), 32'h1);
        check("sel", 32'(selected_ref), 32'h0);
        check("los0", 32'(loss_of_signal_flag[0]), 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check("status", rd & 32'h7, 32'h1);
        check("lock pin", 32'(lock_status_pin), 32'h1);
    endtask
    task automatic t_switch;
        int n;
        run1 <= 1'b1;
        for (n = 0; n < 500 && loss_of_signal_flag[1] !== 1'b0; n++) @(posedge pclk);
        bound(n);
        apb(1'b1, 8'h10, 32'h1F);
        apb(1'b1, 8'h14, 32'h1);
        run0 <= 1'b0;
        for (n = 0; n < 500 && freeze_tracking !== 1'b1; n++) @(posedge pclk);
        bound(n);
        for (n = 0; n < 500 && hitless_switch !== 1'b1; n++) @(posedge pclk);
        bound(n);
        check("lock kept", 32'(pll_state), 32'h1);
        repeat (3) @(posedge pclk);
        check("sel", 32'(selected_ref), 32'h1);
        check("los0", 32'(loss_of_signal_flag[0]), 32'h1);
        check("irq", 32'(interrupt_out_n), 32'h0);
        apb(1'b1, 8'h14, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq masked", 32'(interrupt_out_n), 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq unmasked", 32'(interrupt_out_n), 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq cleared", 32'(interrupt_out_n), 32'h1);
    endtask
    task automatic t_revert;
        int n;
        run0 <= 1'b1;
        repeat (150) @(posedge pclk);
        check("nonrev", 32'(selected_ref), 32'h1);
        check("los0 back", 32'(loss_of_signal_flag[0]), 32'h0);
        apb(1'b1, 8'h00, 32'h4);
        for (n = 0; n < 500 && selected_ref !== 1'b0; n++) @(posedge pclk);
        bound(n);
        check("rev lock", 32'(pll_state), 32'h1);
        apb(1'b1, 8'h00, 32'hC);
        for (n = 0; n < 500 && selected_ref !== 1'b1; n++) @(posedge pclk);
        bound(n);
        apb(1'b1, 8'h00, 32'h1);
        for (n = 0; n < 500 && selected_ref !== 1'b0; n++) @(posedge pclk);
        bound(n);
        check("ref0 lock", 32'(pll_state), 32'h1);
    endtask
    task automatic t_manual;
        int n;
        clock_select_pin <= 1'b1;
        apb(1'b1, 8'h00, 32'h3);
        for (n = 0; n < 500 && selected_ref !== 1'b1; n++) @(posedge pclk);
        bound(n);
        clock_select_pin <= 1'b0;
        for (n = 0; n < 500 && selected_ref !== 1'b0; n++) @(posedge pclk);
        bound(n);
        apb(1'b1, 8'h00, 32'h22);
        for (n = 0; n < 500 && selected_ref !== 1'b1; n++) @(posedge pclk);
        bound(n);
        run1 <= 1'b0;
        for (n = 0; n < 500 && pll_state !== 2'h2; n++) @(posedge pclk);
        bound(n);
        repeat (2) @(posedge pclk);
        check("manual sel", 32'(selected_ref), 32'h1);
        check("steer", 32'(holdover_steer), 32'h2);
        check("hold pin", 32'(holdover_status_pin), 32'h1);
    endtask
    task automatic t_hold;
        int n;
        apb(1'b1, 8'h00, 32'h30);
        for (n = 0; n < 500 && pll_state !== 2'h1; n++) @(posedge pclk);
        bound(n);
        check("sel", 32'(selected_ref), 32'h0);
        run0 <= 1'b0;
        for (n = 0; n < 500 && pll_state !== 2'h2; n++) @(posedge pclk);
        bound(n);
        repeat (2) @(posedge pclk);
        check("steer", 32'(holdover_steer), 32'h3);
        check("lock pin", 32'(lock_status_pin), 32'h0);
    endtask
    task automatic t_eeprom;
        int n;
        apb(1'b1, 8'h10, 32'h1F);
        apb(1'b1, 8'h18, 32'h3);
        n = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0);
            n++;
        end while (rd[4] !== 1'b1 && n < 500);
        bound(n);
        apb(1'b0, 8'h04, 32'h0);
        check("mon0", rd, 32'h12);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", rd, 32'h20);
    endtask
////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_lock;
        t_switch;
        t_revert;
        t_manual;
        t_hold;
        t_eeprom;
        final_report;
    end
endmodule
`default_nettype wire
